/* rtl/sae_encoder_port.sv */
/*
  Slave end of a synchronous serial absolute position link for a multiturn
  encoder: preset and direction inputs, periodic sampling, a sample FIFO,
  and the frame shifter with monoflop repeat.
  Assumes the master clock, preset and direction arrive asynchronously and
  the raw shaft count comes from same-clock sensor logic.
*/
//
// What this block does
// - Burst inside monoflop resends previous word.
// - Burst after monoflop sends fresh sample.
// - Word holds 24 turn, 10-14 angle bits.
// - Preset input high zeroes the position.
// - New position readable at the next 2 ms refresh after one millisecond.
// - Preset processing busy two hundred milliseconds.
// - Direction high makes counterclockwise count up.
// - Direction change applies after one millisecond.
// - Data invalid for 150 ms after power-up.
`timescale 1ns/1ns
module sae_encoder_port import sae_pkg::*; #(
  parameter int ANGLE_BITS = 14,
  parameter logic GRAY_CODE = CODE_GRAY,
  parameter int POWERON_CYCLES = POWERON_CYC,
  parameter int SET_BUSY_CYCLES = SET_BUSY_CYC,
  parameter int SET_DELAY_CYCLES = SET_DELAY_CYC,
  parameter int DIR_DELAY_CYCLES = DIR_DELAY_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw shaft counter from the sensor front end, clockwise increasing.
  input wire sae_pos_s raw_pos,
  // Serial link pins.
  input wire logic ssi_clk,
  output logic ssi_data,
  // Control pins.
  input wire logic preset_in,
  input wire logic dir_in,
  // Status.
  output logic data_valid,
  output logic preset_busy
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] s1_reg, s2_reg;                 // Two stages: clk, preset, dir.
  logic sclk_d_reg;                           // Delayed clock for edge find.
  // Every pin passes two flip-flops before logic reads it. The reset value
  // of each stage is the idle level of its pin: the link clock idles high,
  // preset and direction idle low. A reset value that differed would show
  // a false preset or a false direction change just after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 3'h4;
      s2_reg <= 3'h4;
      sclk_d_reg <= 1'b1;
    end else begin
      s1_reg <= {ssi_clk, preset_in, dir_in};
      s2_reg <= s1_reg;
      sclk_d_reg <= s2_reg[2];
    end
  end
  // Edges of the link clock, one core cycle wide. The link clock is far
  // slower than the core clock, so no edge is ever missed; the cost is a
  // latency of about three core cycles on every link edge.
  logic sclk_fall, sclk_rise;
  assign sclk_fall = sclk_d_reg && !s2_reg[2];
  assign sclk_rise = !sclk_d_reg && s2_reg[2];

  // Gray conversion, applied to outgoing words when GRAY_CODE is set.
  function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // ----------------------------------------------------------------------
  // Timers: power-on, preset filter, preset busy, direction, refresh
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] pon_reg, pon_next;
  logic [CNT_W-1:0] setf_reg, setf_next;
  logic [CNT_W-1:0] busy_reg, busy_next;
  logic [CNT_W-1:0] dirf_reg, dirf_next;
  logic [CNT_W-1:0] ref_reg, ref_next;
  logic dir_reg, dir_next;                    // Applied direction.
  logic [POS_W-1:0] offs_reg, offs_next;      // Preset offset.
  logic set_done_reg, set_done_next;          // Preset taken this high level.
  logic tick;                                 // One-cycle refresh enable.
  logic [POS_W-1:0] raw_dir;

  assign tick = (ref_reg == '0);
  // Reverse the count sense when counterclockwise is selected.
  assign raw_dir = dir_reg ? (~raw_pos + 1'b1) : raw_pos;

  // Next values for all timers and control state.
  // The power-on timer counts down once and then rests at zero, which is
  // what makes data valid. The refresh timer runs freely and makes the
  // one-cycle sample enable. The busy timer is loaded by a preset.
  always_comb begin
    pon_next = (pon_reg != '0) ? pon_reg - 1'b1 : pon_reg;
    ref_next = tick ? CNT_W'(REFRESH_CYCLES - 1) : ref_reg - 1'b1;
    busy_next = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
    setf_next = setf_reg;
    set_done_next = set_done_reg;
    offs_next = offs_reg;
    dirf_next = dirf_reg;
    dir_next = dir_reg;
    // The preset triggers after the input delay and is taken once per high
    // level; the master's longer hold only keeps it asserted.
    if (!s2_reg[1]) begin
      setf_next = '0;
      set_done_next = 1'b0;
    end else if (!set_done_reg) begin
      // The new zero shows in the very next refresh sample after the delay.
      if (setf_reg == CNT_W'(SET_DELAY_CYCLES - 1)) begin
        offs_next = raw_dir;
        set_done_next = 1'b1;
        busy_next = CNT_W'(SET_BUSY_CYCLES);
      end else begin
        setf_next = setf_reg + 1'b1;
      end
    end
    // Direction follows its pin after a short filter.
    if (s2_reg[0] == dir_reg) begin
      dirf_next = '0;
    end else if (dirf_reg == CNT_W'(DIR_DELAY_CYCLES - 1)) begin
      dir_next = s2_reg[0];
      // Reversing the sense negates the reported word, so the offset is
      // negated with it: a zero set by a preset stays at the same shaft
      // position whichever way the count runs.
      offs_next = ~offs_reg + 1'b1;
      dirf_next = '0;
    end else begin
      dirf_next = dirf_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pon_reg <= CNT_W'(POWERON_CYCLES);
      setf_reg <= '0;
      busy_reg <= '0;
      dirf_reg <= '0;
      ref_reg <= '0;
      dir_reg <= 1'b0;
      offs_reg <= '0;
      set_done_reg <= 1'b0;
    end else begin
      pon_reg <= pon_next;
      setf_reg <= setf_next;
      busy_reg <= busy_next;
      dirf_reg <= dirf_next;
      ref_reg <= ref_next;
      dir_reg <= dir_next;
      offs_reg <= offs_next;
      set_done_reg <= set_done_next;
    end
  end
  assign data_valid = (pon_reg == '0);
  assign preset_busy = (busy_reg != '0);

  // ----------------------------------------------------------------------
  // Sample FIFO: periodic samples queue here, the shifter drains them
  // ----------------------------------------------------------------------
  logic [POS_W-1:0] samp;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [POS_W-1:0] fifo_out;
  // Masking the angle below the ordered resolution keeps the word MSB-aligned.
  assign samp = (raw_dir - offs_reg) & {{TURN_W{1'b1}},
    ANGLE_W'({ANGLE_W{1'b1}} << (ANGLE_W - ANGLE_BITS))};

  sae_fifo #(.WIDTH(POS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tick && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .in_data(samp),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ----------------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------------
  sae_state_e st_reg, st_next;
  logic [POS_W-1:0] fresh_reg, fresh_next;    // Newest drained sample.
  logic [POS_W-1:0] last_reg, last_next;      // Word of the last frame.
  logic [POS_W-1:0] sh_reg, sh_next;          // Shift register.
  logic [CNT_W-1:0] mono_reg, mono_next;      // Quiet-time counter.
  logic out_reg, out_next;

  // Drain all queued samples so the freshest is always at hand.
  // The queue never fills in practice, since it is drained every cycle;
  // it decouples the refresh enable from the shifter's own timing.
  assign fifo_pop = fifo_out_valid;

  // Frame shifter next state. A falling link edge in idle latches the word,
  // each rising edge puts the next bit out, and the quiet-time counter
  // decides when a burst is over. A new burst before that time resends
  // the previous word; after it the shifter is idle and latches anew.
  // Limitation: the repeat test uses a fixed count of quiet core cycles,
  // so a link clock slower than the monoflop time would end a frame early.
  always_comb begin
    st_next = st_reg;
    fresh_next = fifo_out_valid ? fifo_out : fresh_reg;
    last_next = last_reg;
    sh_next = sh_reg;
    mono_next = mono_reg;
    out_next = out_reg;
    case (st_reg)
      SAE_IDLE: begin
        out_next = 1'b1;
        if (sclk_fall) begin
          // First edge latches a fresh sample.
          last_next = GRAY_CODE ? to_gray(fresh_reg) : fresh_reg;
          sh_next = last_next;
          st_next = SAE_SHIFT;
          mono_next = '0;
        end
      end
      SAE_SHIFT: begin
        if (sclk_rise) begin
          out_next = sh_reg[POS_W-1];
          sh_next = {sh_reg[POS_W-2:0], 1'b0};
          mono_next = '0;
        end else if (mono_reg == CNT_W'(MONOFLOP_CYC)) begin
          st_next = SAE_IDLE;
        end else begin
          mono_next = mono_reg + 1'b1;
          if (sclk_fall) begin
            mono_next = '0;
          end
        end
        if (mono_reg > CNT_W'(4) && sclk_fall) begin
          sh_next = last_reg;
        end
      end
      default: begin
        st_next = SAE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SAE_IDLE;
      fresh_reg <= '0;
      last_reg <= '0;
      sh_reg <= '0;
      mono_reg <= '0;
      out_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      fresh_reg <= fresh_next;
      last_reg <= last_next;
      sh_reg <= sh_next;
      mono_reg <= mono_next;
      out_reg <= out_next;
    end
  end
  assign ssi_data = out_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_idle_data_high: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == SAE_IDLE) |=> ssi_data) else $error("Data not high in idle.");
  a_busy_after_set: assert property (@(posedge clk) disable iff (!rst_n)
    (!set_done_reg && set_done_next) |=> preset_busy[*8])
    else $error("Preset busy not held.");
  a_valid_stays: assert property (@(posedge clk) disable iff (!rst_n)
    data_valid |=> data_valid) else $error("Valid dropped.");
  a_tick_loads: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> (ref_reg == CNT_W'(REFRESH_CYCLES - 1))) else $error("Refresh lost.");
  a_latch_fresh: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == SAE_IDLE && sclk_fall) |=> (st_reg == SAE_SHIFT))
    else $error("Burst not started.");
  // Once the quiet time has run out the shifter must fall back to idle, so
  // that the next burst carries a fresh sample rather than the old word.
  a_mono_expiry: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == SAE_SHIFT && mono_reg == CNT_W'(MONOFLOP_CYC) && !sclk_rise)
    |=> (st_reg == SAE_IDLE)) else $error("Monoflop did not expire.");
endmodule : sae_encoder_port

/* rtl/sae_pkg.sv */
/*
  Package for the serial absolute encoder port: timing constants, widths,
  code selection and the packed structs that carry position data.
  Assumes a single 10 MHz core clock; all times convert from it.
*/
package sae_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;          // Core clock rate in hertz.
  localparam int MONOFLOP_NS = 15_000;         // Repeat window, longest, ns.
  localparam int MONOFLOP_CYC = (MONOFLOP_NS / 100 < 1) ? 1 : MONOFLOP_NS / 100;
  localparam int SET_DELAY_US = 1_000;         // Preset input delay, us.
  localparam int SET_DELAY_CYC = SET_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int SET_BUSY_MS = 200;            // Preset processing time, ms.
  localparam int SET_BUSY_CYC = SET_BUSY_MS * (CLK_HZ / 1_000);
  localparam int DIR_DELAY_US = 1_000;         // Direction response, us.
  localparam int DIR_DELAY_CYC = DIR_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int POWERON_MS = 150;             // Power-on settle time, ms.
  localparam int POWERON_CYC = POWERON_MS * (CLK_HZ / 1_000);
  localparam int REFRESH_US = 2_000;           // Position refresh period, us.
  localparam int REFRESH_CYC = REFRESH_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int TURN_W = 24;                  // Revolution count width.
  localparam int ANGLE_W = 14;                 // Widest in-turn resolution.
  localparam int POS_W = TURN_W + ANGLE_W;     // Full position word width.
  localparam int CNT_W = 32;                   // Width of timing counters.
  localparam logic CODE_GRAY = 1'b1;           // Code select: Gray.
  localparam logic CODE_BIN = 1'b0;            // Code select: binary.

  // Position word as sent: turns above angle.
  typedef struct packed {
    logic [TURN_W-1:0] turns;
    logic [ANGLE_W-1:0] angle;
  } sae_pos_s;

  // Frame shifter states.
  typedef enum logic [1:0] {
    SAE_IDLE,
    SAE_SHIFT,
    SAE_MONO
  } sae_state_e;

endpackage : sae_pkg

/* rtl/sae_fifo.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock domain and asynchronous active-low reset.
*/
`timescale 1ns/1ns
module sae_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [DEPTH];          // Word storage.
  logic [AW-1:0] wr_reg, wr_next;             // Write index.
  logic [AW-1:0] rd_reg, rd_next;             // Read index.
  logic [AW:0] cnt_reg, cnt_next;             // Fill level.
  logic push, pop;

  // Handshakes come straight from the fill level.
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointer and level values.
  always_comb begin
    wr_next = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register pointers; storage holds no reset to keep it cheap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : sae_fifo

/* bench/sae_ssi_master.sv */
/*
  Model of the link master: clock bursts of one word, data sampled MSB first.
  Assumes a 10 MHz bench clock and a link period of 800 ns.
*/
`timescale 1ns/1ns
module sae_ssi_master import sae_pkg::*; (
  // Link pins.
  output logic ssi_clk,
  input wire logic ssi_data
);
  // The clock stands high between frames, as an idle master leaves it.
  initial ssi_clk = 1'b1;

  // One burst; each bit is taken late in its period, well after it settles.
  task automatic frame(output logic [POS_W-1:0] word);
    word = '0;
    for (int i = 0; i <= POS_W; i++) begin
      if (i < POS_W) ssi_clk = 1'b0;
      #350;
      if (i > 0) word = {word[POS_W-2:0], ssi_data};
      #50;
      if (i < POS_W) ssi_clk = 1'b1;
      #400;
    end
  endtask : frame
endmodule : sae_ssi_master

/* bench/tb.sv */
/*
  Self-checking bench for the encoder port and its sample FIFO.
  Assumes short counts set here and a link master model beside the port.
*/
`timescale 1ns/1ns
module tb import sae_pkg::*; ;
  // --------------------------------
  // Signals and instances
  // --------------------------------
  localparam int PON = 50; // Shortened power-on time.
  localparam int BUSY = 40; // Shortened preset processing time.
  localparam int REF = 20; // Shortened refresh period.
  localparam int GAP = MONOFLOP_CYC + 3 * REF + 10; // Quiet time for fresh data.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sae_pos_s raw_pos = '0;
  logic preset_in = 1'b0;
  logic dir_in = 1'b0;
  logic ssi_clk;
  logic ssi_data;
  logic data_valid;
  logic preset_busy;
  logic [POS_W-1:0] word;
  logic [POS_W-1:0] exp;
  int errors = 0;
  int comparisons = 0;

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  sae_encoder_port #(.ANGLE_BITS(14), .GRAY_CODE(CODE_BIN), .POWERON_CYCLES(PON),
    .SET_BUSY_CYCLES(BUSY), .SET_DELAY_CYCLES(10), .DIR_DELAY_CYCLES(10),
    .REFRESH_CYCLES(REF), .FIFO_DEPTH(8)) i_dut (.clk(clk), .rst_n(rst_n),
    .raw_pos(raw_pos), .ssi_clk(ssi_clk), .ssi_data(ssi_data), .preset_in(preset_in),
    .dir_in(dir_in), .data_valid(data_valid), .preset_busy(preset_busy));
  sae_ssi_master i_master (.ssi_clk(ssi_clk), .ssi_data(ssi_data));

  // --------------------------------
  // Shared tasks
  // --------------------------------
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(logic [63:0] seen, logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // Waits quietly, then reads one word through the master.
  task automatic read_after(int cycles);
    repeat (cycles) @(negedge clk);
    i_master.frame(word);
  endtask : read_after

  // --------------------------------
  // Scenarios
  // --------------------------------
  // Outputs idle in reset; data is flagged valid only after power-on time.
  task automatic t_reset();
    repeat (5) @(negedge clk);
    check(ssi_data, 1'b1);
    check(data_valid, 1'b0);
    check(preset_busy, 1'b0);
    rst_n = 1'b1;
    repeat (PON - 10) @(negedge clk);
    check(data_valid, 1'b0);
    repeat (20) @(negedge clk);
    check(data_valid, 1'b1);
  endtask : t_reset

  // Fresh word after quiet time, repeat inside the window, fresh again later.
  task automatic t_fresh();
    raw_pos = '{turns: 24'hA5C3E1, angle: 14'h2D4B};
    read_after(GAP);
    check(word, 38'h29_70F8_6D4B);
    raw_pos.turns = 24'hA5C3E2;
    read_after(20);
    check(word, 38'h29_70F8_6D4B);
    read_after(GAP);
    check(word, 38'h29_70F8_AD4B);
  endtask : t_fresh

  // Direction high makes the count run the other way, then back.
  task automatic t_dir();
    dir_in = 1'b1;
    exp = ~38'h29_70F8_AD4B + 38'h1;
    read_after(GAP);
    check(word, exp);
    dir_in = 1'b0;
    read_after(GAP);
    check(word, 38'h29_70F8_AD4B);
  endtask : t_dir

  // Preset zeroes the word, shows busy for its processing time, keeps offset.
  task automatic t_preset();
    int n;
    n = 0;
    preset_in = 1'b1;
    while (preset_busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(preset_busy, 1'b1);
    repeat (BUSY - 3) @(negedge clk);
    check(preset_busy, 1'b1);
    preset_in = 1'b0;
    repeat (8) @(negedge clk);
    check(preset_busy, 1'b0);
    read_after(GAP);
    check(word, 38'h0);
    raw_pos.turns = 24'hA5C3E5;
    read_after(GAP);
    check(word, 38'h0_0000_C000);
  endtask : t_preset

  // Samples through the port's queue: each read shows the newest sample
  // relative to the preset zero; after the quiet time the line idles high.
  task automatic t_fifo();
    for (int k = 1; k < 4; k++) begin
      raw_pos = '{turns: 24'hA5C3E2, angle: 14'h2D4B + 14'(k)};
      read_after(GAP);
      check(word, 38'(k));
    end
    raw_pos = '{turns: 24'hA5C3E3, angle: 14'h2D4B};
    read_after(GAP);
    check(word, 38'h4000);
    repeat (MONOFLOP_CYC + 10) @(negedge clk);
    check(ssi_data, 1'b1);
    check(data_valid, 1'b1);
    check(preset_busy, 1'b0);
  endtask : t_fifo

  // Main sequence.
  initial begin
    t_reset();
    t_fresh();
    t_dir();
    t_preset();
    t_fifo();
    test_done();
  end

  // Watchdog: the tests need about 6000 cycles, so 20000 means a hang.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : tb
